// ---- rtl/code_protect_lock.sv ----
// Code protection lock: encryption array, lock bits, signature bytes, APB registers
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "code_protect_cfg.svh"
module code_protect_lock #(
    parameter int ENC_AW = `CPL_ENC_AW,
    parameter logic [7:0] SIG0 = 8'h5A, // Arbitrary value
    parameter logic [7:0] SIG1 = 8'hA5, // Arbitrary value
    parameter logic [7:0] SIG2 = 8'h3C, // Arbitrary value
    parameter logic [7:0] SIG3 = 8'hC3  // Arbitrary value
) (
    input wire logic clk,                  // Core clock
    input wire logic reset_n,              // Async reset, active low
    input wire logic ce,                   // Clock enable, freezes state when low
    input wire logic psel,                 // APB select
    input wire logic penable,              // APB enable
    input wire logic pwrite,               // APB direction
    input wire logic [7:0] paddr,          // APB byte address
    input wire logic [31:0] pwdata,        // APB write data
    output logic [31:0] prdata_ff,         // APB read data
    output logic pready_ff,                // APB ready
    output logic pslverr_ff,               // APB error
    input wire logic external_access_pin,  // External access pin, asynchronous
    input wire logic verify_req,           // Verify read of one code byte
    input wire logic [15:0] verify_addr,   // Verify address
    input wire logic [7:0] verify_code,    // Raw code byte at verify_addr
    output code_protect_pkg::rsp_t verify_rsp_ff, // Verify answer
    input wire logic movc_req,             // Table read of an internal byte
    input wire logic movc_ext,             // Table read runs from external memory
    input wire logic [7:0] movc_code,      // Raw internal code byte
    output code_protect_pkg::rsp_t movc_rsp_ff,   // Table read answer
    input wire logic prog_req,             // Request to program a code byte
    output code_protect_pkg::rsp_t prog_rsp_ff,   // Programming grant or refusal
    input wire logic ext_fetch_req,        // Fetch from external program memory
    output code_protect_pkg::rsp_t ext_fetch_rsp_ff, // Fetch grant or refusal
    output code_protect_pkg::level_t level_ff,    // Active protection level
    output logic ea_effective_ff           // External access level in force
);
    localparam int ENC_DEPTH = 1 << ENC_AW;

    if (ENC_AW < 1 || ENC_AW > 16) begin : g_bad_enc_aw
        $error("ENC_AW must lie between 1 and 16");
    end

    // Reset release through two flip-flops
    logic rst_meta_ff;
    logic rst_n_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // Pin synchroniser runs without reset so the level is valid at release
    logic ea_meta_ff;
    logic ea_sync_ff;
    always_ff @(posedge clk) begin
        ea_meta_ff <= external_access_pin;
        ea_sync_ff <= ea_meta_ff;
    end

    logic [`CPL_LOCK_W-1:0] lock_ff;
    logic [`CPL_LOCK_W-1:0] nxt_lock;
    logic [7:0] enc_mem_ff [ENC_DEPTH];
    logic [7:0] nxt_enc_mem [ENC_DEPTH];
    logic [ENC_AW-1:0] enc_idx_ff;
    logic [ENC_AW-1:0] nxt_enc_idx;
    logic ea_latch_ff;
    logic nxt_ea_latch;
    logic ea_done_ff;
    logic nxt_ea_done;
    logic [31:0] nxt_prdata;
    logic nxt_pready;
    logic nxt_pslverr;
    code_protect_pkg::rsp_t nxt_verify_rsp;
    code_protect_pkg::rsp_t nxt_movc_rsp;
    code_protect_pkg::rsp_t nxt_prog_rsp;
    code_protect_pkg::rsp_t nxt_fetch_rsp;
    code_protect_pkg::level_t lvl;
    logic nxt_ea_eff;
    logic [7:0] enc_sel;
    logic acc;
    logic done;
    logic wr_ok;

    // Highest programmed bit wins, so adding bits never loosens protection
    always_comb begin
        if (lock_ff[2]) begin
            lvl = code_protect_pkg::LVL4;
        end else if (lock_ff[1]) begin
            lvl = code_protect_pkg::LVL3;
        end else if (lock_ff[0]) begin
            lvl = code_protect_pkg::LVL2;
        end else begin
            lvl = code_protect_pkg::LVL1;
        end
    end

    assign enc_sel = enc_mem_ff[verify_addr[ENC_AW-1:0]];
    assign acc = psel & penable;
    assign done = acc & pready_ff;

    // Register bus, one wait state so the answer comes from flops
    always_comb begin
        nxt_pready = acc & ~pready_ff;
        nxt_prdata = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        wr_ok = 1'b0;
        if (acc && !pready_ff) begin
            unique case (paddr)
                `CPL_OFF_LOCK: begin
                    nxt_prdata[`CPL_LOCK_W-1:0] = lock_ff;
                    nxt_prdata[`CPL_LVL_LSB +: 2] = lvl;
                    nxt_prdata[`CPL_EA_LATCH_BIT] = ea_latch_ff;
                    nxt_prdata[`CPL_EA_DONE_BIT] = ea_done_ff;
                end
                `CPL_OFF_ENC_IDX: begin
                    nxt_prdata[ENC_AW-1:0] = enc_idx_ff;
                end
                `CPL_OFF_ENC_DATA: begin
                    // Array content is only visible while unlocked
                    if (lvl == code_protect_pkg::LVL1) begin
                        nxt_prdata[7:0] = enc_mem_ff[enc_idx_ff];
                    end
                    nxt_pslverr = pwrite && (lvl != code_protect_pkg::LVL1);
                end
                `CPL_OFF_SIG: begin
                    nxt_prdata = {SIG3, SIG2, SIG1, SIG0};
                    nxt_pslverr = pwrite;
                end
                default: begin
                    nxt_pslverr = 1'b1;
                end
            endcase
        end
        if (done && pwrite && !pslverr_ff) begin
            wr_ok = 1'b1;
        end
    end

    // One-time storage: programming only clears array bits or sets lock bits
    always_comb begin
        nxt_lock = lock_ff;
        nxt_enc_idx = enc_idx_ff;
        nxt_enc_mem = enc_mem_ff;
        if (wr_ok) begin
            unique case (paddr)
                `CPL_OFF_LOCK: begin
                    nxt_lock = lock_ff | pwdata[`CPL_LOCK_W-1:0];
                end
                `CPL_OFF_ENC_IDX: begin
                    nxt_enc_idx = pwdata[ENC_AW-1:0];
                end
                `CPL_OFF_ENC_DATA: begin
                    nxt_enc_mem[enc_idx_ff] = enc_mem_ff[enc_idx_ff] & pwdata[7:0];
                end
                default: begin
                    nxt_lock = lock_ff;
                end
            endcase
        end
    end

    // External access level is caught once after release
    always_comb begin
        nxt_ea_done = 1'b1;
        nxt_ea_latch = ea_done_ff ? ea_latch_ff : ea_sync_ff;
        nxt_ea_eff = (lvl == code_protect_pkg::LVL1) ? ea_sync_ff : ea_latch_ff;
    end

    // Answers to the core and the programmer
    always_comb begin
        nxt_verify_rsp = '0;
        nxt_movc_rsp = '0;
        nxt_prog_rsp = '0;
        nxt_fetch_rsp = '0;
        if (verify_req) begin
            nxt_verify_rsp.valid = 1'b1;
            if (lvl == code_protect_pkg::LVL3 || lvl == code_protect_pkg::LVL4) begin
                nxt_verify_rsp.refused = 1'b1;
            end else begin
                nxt_verify_rsp.data = ~(verify_code ^ enc_sel);
            end
        end
        if (movc_req) begin
            nxt_movc_rsp.valid = 1'b1;
            if (movc_ext && lvl != code_protect_pkg::LVL1) begin
                nxt_movc_rsp.refused = 1'b1;
            end else begin
                nxt_movc_rsp.data = movc_code;
            end
        end
        if (prog_req) begin
            nxt_prog_rsp.valid = 1'b1;
            nxt_prog_rsp.refused = (lvl != code_protect_pkg::LVL1);
        end
        if (ext_fetch_req) begin
            nxt_fetch_rsp.valid = 1'b1;
            nxt_fetch_rsp.refused = (lvl == code_protect_pkg::LVL4);
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            lock_ff <= `CPL_LOCK_RST;
            enc_idx_ff <= '0;
            for (int i = 0; i < ENC_DEPTH; i++) begin
                enc_mem_ff[i] <= `CPL_ENC_RST;
            end
            ea_latch_ff <= 1'b0;
            ea_done_ff <= 1'b0;
            ea_effective_ff <= 1'b0;
            level_ff <= code_protect_pkg::LVL1;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            verify_rsp_ff <= '0;
            movc_rsp_ff <= '0;
            prog_rsp_ff <= '0;
            ext_fetch_rsp_ff <= '0;
        end else if (ce) begin
            lock_ff <= nxt_lock;
            enc_idx_ff <= nxt_enc_idx;
            enc_mem_ff <= nxt_enc_mem;
            ea_latch_ff <= nxt_ea_latch;
            ea_done_ff <= nxt_ea_done;
            ea_effective_ff <= nxt_ea_eff;
            level_ff <= lvl;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            verify_rsp_ff <= nxt_verify_rsp;
            movc_rsp_ff <= nxt_movc_rsp;
            prog_rsp_ff <= nxt_prog_rsp;
            ext_fetch_rsp_ff <= nxt_fetch_rsp;
        end
    end

    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n_ff);

    property p_verify_xnor;
        ce && verify_req && !lock_ff[2] && !lock_ff[1]
            |=> verify_rsp_ff.valid && !verify_rsp_ff.refused
                && verify_rsp_ff.data == ~($past(verify_code) ^ $past(enc_sel));
    endproperty
    a_verify_xnor: assert property (p_verify_xnor) else $error("verify data not XNOR");

    property p_enc_pick;
        ce && verify_req && !lock_ff[2] && !lock_ff[1] && !wr_ok
            |=> verify_rsp_ff.data == ~($past(verify_code)
                ^ enc_mem_ff[$past(verify_addr[ENC_AW-1:0])]);
    endproperty
    a_enc_pick: assert property (p_enc_pick) else $error("wrong encryption byte");

    property p_verify_off;
        ce && verify_req && (lock_ff[2] || lock_ff[1]) |=> verify_rsp_ff.refused;
    endproperty
    a_verify_off: assert property (p_verify_off) else $error("verify not disabled");

    property p_movc_block;
        ce && movc_req && movc_ext && lock_ff != 3'h0 |=> movc_rsp_ff.valid
            && movc_rsp_ff.refused && movc_rsp_ff.data == 8'h00;
    endproperty
    a_movc_block: assert property (p_movc_block) else $error("table read leaked");

    property p_movc_plain;
        ce && movc_req && lock_ff == 3'h0 |=> movc_rsp_ff.data == $past(movc_code);
    endproperty
    a_movc_plain: assert property (p_movc_plain) else $error("table read not plain");

    property p_prog_refuse;
        ce && prog_req && lock_ff != 3'h0 |=> prog_rsp_ff.refused;
    endproperty
    a_prog_refuse: assert property (p_prog_refuse) else $error("program not refused");

    property p_fetch_off;
        ce && ext_fetch_req |=> ext_fetch_rsp_ff.refused == $past(lock_ff[2]);
    endproperty
    a_fetch_off: assert property (p_fetch_off) else $error("external fetch gate wrong");

    property p_ea_hold;
        ea_done_ff |=> $stable(ea_latch_ff);
    endproperty
    a_ea_hold: assert property (p_ea_hold) else $error("latched pin level moved");

    property p_lock_sticky;
        ##1 ($past(lock_ff) & ~lock_ff) == 3'h0;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");

    property p_level_up;
        ##1 level_ff >= $past(level_ff);
    endproperty
    a_level_up: assert property (p_level_up) else $error("level decreased");

    c_verify: cover property (ce && verify_req ##1 verify_rsp_ff.valid);
    c_lock_all: cover property (lock_ff == 3'h7);
    c_enc_write: cover property (wr_ok && paddr == `CPL_OFF_ENC_DATA);
    c_movc_block: cover property (movc_rsp_ff.refused);
endmodule
`default_nettype wire

// ---- rtl/code_protect_cfg.svh ----
// Offsets, field positions and reset values of the code protection lock block
//
// Behaviour
// - The encryption array holds 64 bytes that read as all ones until programmed.
// - During verify the low six address lines pick the encryption byte that applies.
// - The verify result is the XNOR of code byte and encryption byte, so a blank array is transparent.
// - Three one-time lock bits, each unprogrammed or programmed, select the protection level.
// - At level 1 nothing is locked, verify is still encrypted and external table reads get plain data.
// - At level 2 table reads executed from external memory cannot fetch internal code bytes.
// - At level 2 and above the external access pin is caught once after reset and held until the next reset.
// - At level 2 and above any further programming of the program memory is refused.
// - At level 3 every level 2 restriction applies and verify read-back is disabled as well.
// - At level 4 every level 3 restriction applies and execution from external memory is forbidden.
// - A separate signature array exists that the user cannot program.
// - The signature array holds four factory bytes readable by an external programmer.
`ifndef CODE_PROTECT_CFG_SVH
`define CODE_PROTECT_CFG_SVH

`define CPL_OFF_LOCK 8'h00
`define CPL_OFF_ENC_IDX 8'h04
`define CPL_OFF_ENC_DATA 8'h08
`define CPL_OFF_SIG 8'h0C

`define CPL_LOCK_W 3
`define CPL_LVL_LSB 4
`define CPL_EA_LATCH_BIT 8
`define CPL_EA_DONE_BIT 9

`define CPL_LOCK_RST 3'h0
`define CPL_ENC_RST 8'hFF
`define CPL_ENC_AW 6

`endif

// ---- rtl/code_protect_pkg.sv ----
// Types shared by the code protection lock block
package code_protect_pkg;
    typedef enum logic [1:0] {
        LVL1 = 2'b00,
        LVL2 = 2'b01,
        LVL3 = 2'b10,
        LVL4 = 2'b11
    } level_t;

    typedef struct packed {
        logic valid;
        logic refused;
        logic [7:0] data;
    } rsp_t;
endpackage

// ---- tb/code_rom_model.sv ----
// Behavioural external program memory image that feeds raw code bytes
`timescale 1ns/1ns
`default_nettype none
module code_rom_model (
    input wire logic [15:0] addr,  // Byte address of the code fetch
    output logic [7:0] data        // Raw code byte at addr
);
    // The bench fills every location with random bytes, which can include blank FF
    logic [7:0] mem [0:255];
    // Upper address lines alias onto the small image; enough to reach every encryption byte
    assign data = mem[addr[7:0]];
endmodule
`default_nettype wire

// ---- tb/code_protect_lock_tb.sv ----
// Self-checking bench for the code protection lock block
`timescale 1ns/1ns
`default_nettype none
`include "code_protect_cfg.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module code_protect_lock_tb;
    localparam logic [7:0] S0 = 8'h96; // Arbitrary value
    localparam logic [7:0] S1 = 8'h1E; // Arbitrary value
    localparam logic [7:0] S2 = 8'hE1; // Arbitrary value
    localparam logic [7:0] S3 = 8'h69; // Arbitrary value
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;
    int lock_m;
    int latch_m;
    int enc_m [64];
    int img [256];
    logic [31:0] seed = 32'h45EC;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pin = 1'b1;
    logic verify_req = 1'b0;
    logic movc_req = 1'b0;
    logic movc_ext = 1'b0;
    logic prog_req = 1'b0;
    logic fetch_req = 1'b0;
    logic [15:0] op_addr = 16'h0;
    logic [7:0] code;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    code_protect_pkg::rsp_t verify_rsp_ff, movc_rsp_ff, prog_rsp_ff, fetch_rsp_ff;
    code_protect_pkg::level_t level_ff;
    logic ea_effective_ff;
    code_rom_model u_rom (.addr(op_addr), .data(code));
    code_protect_lock #(.SIG0(S0), .SIG1(S1), .SIG2(S2), .SIG3(S3)) u_dut (
        .clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
        .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .external_access_pin(pin),
        .verify_req(verify_req), .verify_addr(op_addr), .verify_code(code),
        .verify_rsp_ff(verify_rsp_ff), .movc_req(movc_req), .movc_ext(movc_ext),
        .movc_code(code), .movc_rsp_ff(movc_rsp_ff), .prog_req(prog_req),
        .prog_rsp_ff(prog_rsp_ff), .ext_fetch_req(fetch_req),
        .ext_fetch_rsp_ff(fetch_rsp_ff), .level_ff(level_ff),
        .ea_effective_ff(ea_effective_ff));
    initial begin
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int lvl();
        return lock_m[2] ? 3 : lock_m[1] ? 2 : lock_m[0] ? 1 : 0;
    endfunction
    function automatic int expect_rsp(int k, int ext, int c, int a);
        int rf;
        int d;
        d = 0;
        case (k)
            0: begin
                rf = lvl() >= 2;
                d = ~(c ^ enc_m[a & 63]) & 255;
            end
            1: begin
                rf = ext && lvl() >= 1;
                d = c;
            end
            2: rf = lvl() >= 1;
            default: rf = lvl() == 3;
        endcase
        return 512 | (rf << 8) | (rf ? 0 : d);
    endfunction
    task automatic report_and_stop();
        if (fails == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready_ff !== 1'b1);
        rd = prdata_ff;
        err = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic w, input int d, input int ed,
                        input int ee);
        logic [31:0] rd;
        logic err;
        apb(w, a, d, rd, err);
        if (!w) `CHK("prdata", ed, rd)
        `CHK("pslverr", ee, err)
    endtask
    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        lock_m = 0;
        latch_m = pin;
        foreach (enc_m[i]) enc_m[i] = 255;
    endtask
    task automatic run_ops();
        code_protect_pkg::rsp_t r;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            op_addr <= 16'(rnd());
            movc_ext <= k[0];
            @(posedge clk);
            verify_req <= k[2:1] == 0;
            movc_req <= k[2:1] == 1;
            prog_req <= k[2:1] == 2;
            fetch_req <= k[2:1] == 3;
            @(posedge clk);
            {verify_req, movc_req, prog_req, fetch_req} <= 4'h0;
            #1;
            r = k[2:1] == 0 ? verify_rsp_ff : k[2:1] == 1 ? movc_rsp_ff :
                k[2:1] == 2 ? prog_rsp_ff : fetch_rsp_ff;
            `CHK("core_rsp", expect_rsp(k / 2, k % 2, img[op_addr[7:0]], op_addr), r)
        end
        `CHK("level", lvl(), level_ff)
        @(posedge clk);
        pin <= ~pin;
        repeat (5) @(posedge clk);
        `CHK("ea", lvl() == 0 ? int'(pin) : latch_m, ea_effective_ff)
    endtask
    initial begin
        foreach (img[i]) img[i] = rnd() & 255;
        foreach (img[i]) u_rom.mem[i] = img[i][7:0];
        do_reset();
        rchk(`CPL_OFF_LOCK, 0, 0, 32'h200 | (latch_m << 8), 0);
        rchk(`CPL_OFF_SIG, 0, 0, {S3, S2, S1, S0}, 0);
        rchk(`CPL_OFF_SIG, 1, 0, 0, 1);
        rchk(8'h10, 0, 0, 0, 1);
        rchk(`CPL_OFF_ENC_IDX, 1, 63, 0, 0);
        rchk(`CPL_OFF_ENC_DATA, 0, 0, 255, 0);
        run_ops();
        // Clock enable low must freeze the programming answer register, even with a programming request up
        ce <= 1'b0;
        prog_req <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("frozen_rsp", 0, prog_rsp_ff)
        ce <= 1'b1;
        prog_req <= 1'b0;
        for (int j = 0; j < 6; j++) begin
            int ix;
            int v;
            ix = rnd() & 63;
            v = rnd() & 255;
            rchk(`CPL_OFF_ENC_IDX, 1, ix, 0, 0);
            rchk(`CPL_OFF_ENC_DATA, 1, v, 0, 0);
            enc_m[ix] = enc_m[ix] & v;
            rchk(`CPL_OFF_ENC_DATA, 0, 0, enc_m[ix], 0);
        end
        repeat (4) run_ops();
        // Contents are verified above before any lock bit is set
        for (int c = 1; c < 8; c++) begin
            pin <= c[0];
            do_reset();
            rchk(`CPL_OFF_LOCK, 1, c, 0, 0);
            lock_m = c;
            rchk(`CPL_OFF_LOCK, 0, 0, 32'h200 | (latch_m << 8) | (lvl() << 4) | c, 0);
            rchk(`CPL_OFF_ENC_DATA, 1, 0, 0, 1);
            rchk(`CPL_OFF_ENC_DATA, 0, 0, 0, 0);
            run_ops();
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
